/* File: lcdcd_defines.vh */
// Constants for the LCD command decoder.
`ifndef LCDCD_DEFINES_VH
`define LCDCD_DEFINES_VH
`define LCDCD_OP_TEST 4'h0
`define LCDCD_OP_HOME 4'h1
`define LCDCD_OP_LINE 4'h2
`define LCDCD_OP_DISP 4'h3
`define LCDCD_OP_PSAVE 4'h4
`define LCDCD_OP_PWR 4'h5
`define LCDCD_OP_SYS 4'h6
`define LCDCD_NOP_BYTE 8'h00
`define LCDCD_HOME_ADDR 7'h30
`define LCDCD_ADDR_ZERO 7'h00
`define LCDCD_ADDR_ONE 7'h01
`define LCDCD_TEXT_LO 7'h30
`define LCDCD_TEXT_HI 7'h6f
`define LCDCD_SYM_LO 7'h60
`define LCDCD_DIVIDER_RST 1'b1
`define LCDCD_REG_CTRL 12'h000
`define LCDCD_REG_PWR 12'h004
`define LCDCD_REG_STAT 12'h008
`define LCDCD_REG_CMD 12'h00c
`define LCDCD_FLASH_HZ 2
`define LCDCD_CLK_HZ 20000000
`endif

/* File: lcdcd_flash.v */
// Flash-rate timebase shared by cursor and line blinking.
`timescale 1ns/1ns
`include "lcdcd_defines.vh"
module lcdcd_flash #(
  parameter HALF_CYCLES = `LCDCD_CLK_HZ / (2 * `LCDCD_FLASH_HZ)
) (
  // Clock and reset.
  input wire sys_clk,
  input wire rst_b,
  // Square wave output.
  output reg flash_rate
);
  reg [31:0] count;
  // Toggle the phase every half period; one source keeps line and cursor blink in step.
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      count <= 32'h0000_0000;
      flash_rate <= 1'b0;
    end else if (count >= HALF_CYCLES - 1) begin
      count <= 32'h0000_0000;
      flash_rate <= ~flash_rate;
    end else begin
      count <= count + 32'h0000_0001;
    end
  end
endmodule

/* File: lcdcd_top.v */
// LCD command decoder with APB access to its command port and settings.
// Functional notes
// - cmd_data_sel low command, high data
// - Extended select persists across data writes
// - Cursor home loads address 30h
// - Cursor home clears line scroll
// - Home shows cursor only after basic access
// - Extended 0001 sets scroll amount
// - Basic 0010 sets RAM line flashing
// - Line flash uses cursor flash rate
// - Extended 0010 sets tall font lines
// - Under-bar cursor tall on tall lines
// - Display control loads cursor, flash, select, panel
// - Cursor style from show and flash bits
// - Cursor position follows address counter
// - Symbol area cursor blinks symbol group
// - Power save loads oscillator and save bits
// - Extended power loads divider, bias, ratio
// - System set loads bank, scan, user font
// - Extended system set loads inversion flag
// - Address set loads seven-bit counter
// - Data write increments counter with wrap
// - Icon or contrast address hides cursor
// - Data goes to last selected region
// - Zero byte only clears test mode
//
// Design decisions made here: the APB register port and the register offsets.
`timescale 1ns/1ns
`include "lcdcd_defines.vh"

// Software view of the block, one aligned 32-bit word per register.
// The command port takes one byte per write in bits 7:0; bit 8 set marks a data
// byte for display RAM, bit 8 clear a command byte. The port reads back as zero.
// The control view holds the tall-font lines in bits 15:12, the flashing lines in
// bits 11:8, the scroll amount in bits 7:6, and cursor show, cursor flash, the
// extended select and panel on in bits 3:0.
// The power view holds, from bit 0 upward, oscillator, power save, high drive,
// regulator loop, buffer, booster, divider select, bias, gain ratio, font bank,
// scan direction, user font and segment inversion.
// The status view holds the address counter in bits 6:0, then the hidden-cursor
// flag, the region of the last address set and the test flag.
// Every access has one wait state: pready is high for one cycle, and a byte on
// the command port acts at the edge that raises it.
// Writes to the read-only views are dropped; unmapped offsets answer with pslverr.
// The host must bring the oscillator up before the booster; nothing here checks
// that order, since the booster enable is only stored and passed on.
module lcdcd_top #(
  parameter HALF_CYCLES = `LCDCD_CLK_HZ / (2 * `LCDCD_FLASH_HZ)
) (
  // Clock and reset.
  input wire sys_clk,
  input wire rst_b,
  // APB slave.
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Byte written into display RAM.
  output reg ram_we,
  output reg ram_region,
  output reg [6:0] ram_addr,
  output reg [7:0] ram_data,
  // Display control state.
  output reg [6:0] addr_count,
  output reg [1:0] scroll_amount,
  output reg [3:0] line_flash,
  output reg [3:0] line_tall_font,
  output reg [3:0] line_flash_now,
  output reg cursor_show,
  output reg cursor_flash,
  output reg extended_set_sel,
  output reg panel_on,
  output reg cursor_visible,
  output reg cursor_bar,
  output reg cursor_reverse,
  output reg cursor_tall,
  output reg symbol_flash,
  // Power and system settings.
  output reg osc_on,
  output reg low_power_on,
  output reg high_drive_on,
  output reg lcd_volt_loop_on,
  output reg lcd_buffer_on,
  output reg booster_on,
  output reg internal_divider_sel,
  output reg lcd_bias_sel,
  output reg [1:0] gain_ratio,
  output reg [1:0] font_bank,
  output reg scan_reverse,
  output reg user_font_on,
  output reg seg_invert,
  output reg test_mode
);
  wire flash_rate;
  wire apb_acc;
  wire is_ctrl;
  wire is_pwr;
  wire is_stat;
  wire is_cmd;
  wire wr_byte;
  wire [7:0] wb;
  wire [3:0] op;
  reg region_basic;
  reg cursor_home_ok;
  reg cursor_hidden;
  reg [1:0] cur_line;
  reg in_text;
  reg in_sym;
  reg [31:0] next_rdata;

  // Text RAM lines one to four sit between the two text bounds of the basic map.
  function in_text_area;
    input [6:0] addr;
    begin
      in_text_area = (addr >= `LCDCD_TEXT_LO) && (addr <= `LCDCD_TEXT_HI);
    end
  endfunction

  // The symbol store fills the top of the extended map.
  function in_sym_area;
    input [6:0] addr;
    begin
      in_sym_area = (addr >= `LCDCD_SYM_LO);
    end
  endfunction

  // Text line index, line one at zero, taken from the upper address bits.
  function [1:0] text_line_of;
    input [6:0] addr;
    begin
      text_line_of = addr[5:4] - 2'b11;
    end
  endfunction

  // An address set outside text RAM or the symbol store leaves no cursor to show.
  function hides_cursor;
    input ext;
    input [6:0] addr;
    begin
      hides_cursor = ext ? ~in_sym_area(addr) : ~in_text_area(addr);
    end
  endfunction

  lcdcd_flash #(.HALF_CYCLES(HALF_CYCLES)) u_flash (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .flash_rate(flash_rate)
  );

  // APB access decode; every access is taken in its first access cycle and completes one cycle later.
  assign apb_acc = psel & penable & ~pready;
  assign is_ctrl = (paddr == `LCDCD_REG_CTRL);
  assign is_pwr = (paddr == `LCDCD_REG_PWR);
  assign is_stat = (paddr == `LCDCD_REG_STAT);
  assign is_cmd = (paddr == `LCDCD_REG_CMD);
  assign wr_byte = apb_acc & pwrite & is_cmd;
  assign wb = pwdata[7:0];
  assign op = wb[7:4];

  // Which RAM line and area the counter sits in.
  always @* begin
    in_text = in_text_area(addr_count);
    in_sym = in_sym_area(addr_count);
    cur_line = text_line_of(addr_count);
  end

  // Bus handshake and read mux; unmapped addresses answer with an error.
  always @* begin
    next_rdata = 32'h0000_0000;
    if (is_ctrl) begin
      next_rdata = {16'h0000, line_tall_font, line_flash, scroll_amount, 2'b00,
                    cursor_show, cursor_flash, extended_set_sel, panel_on};
    end else if (is_pwr) begin
      next_rdata = {17'h0000, seg_invert, user_font_on, scan_reverse, font_bank,
                    gain_ratio, lcd_bias_sel, internal_divider_sel, booster_on,
                    lcd_buffer_on, lcd_volt_loop_on, high_drive_on, low_power_on, osc_on};
    end else if (is_stat) begin
      next_rdata = {22'h0000_00, test_mode, region_basic, cursor_hidden, addr_count};
    end
  end

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= apb_acc;
      pslverr <= apb_acc & ~(is_ctrl | is_pwr | is_stat | is_cmd);
      // Read data is caught only on reads, so it stands until the next read.
      if (apb_acc && !pwrite) begin
        prdata <= next_rdata;
      end
    end
  end

  // Command interpreter; bit 8 of the written word is the command/data select.
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ram_we <= 1'b0;
      ram_region <= 1'b0;
      ram_addr <= `LCDCD_ADDR_ZERO;
      ram_data <= 8'h00;
      addr_count <= `LCDCD_ADDR_ZERO;
      scroll_amount <= 2'b00;
      line_flash <= 4'h0;
      line_tall_font <= 4'h0;
      cursor_show <= 1'b0;
      cursor_flash <= 1'b0;
      extended_set_sel <= 1'b0;
      panel_on <= 1'b0;
      osc_on <= 1'b0;
      low_power_on <= 1'b0;
      high_drive_on <= 1'b0;
      lcd_volt_loop_on <= 1'b0;
      lcd_buffer_on <= 1'b0;
      booster_on <= 1'b0;
      internal_divider_sel <= `LCDCD_DIVIDER_RST;
      lcd_bias_sel <= 1'b0;
      gain_ratio <= 2'b00;
      font_bank <= 2'b00;
      scan_reverse <= 1'b0;
      user_font_on <= 1'b0;
      seg_invert <= 1'b0;
      test_mode <= 1'b0;
      region_basic <= 1'b1;
      cursor_home_ok <= 1'b1;
      cursor_hidden <= 1'b0;
    end else begin
      ram_we <= 1'b0;
      if (wr_byte && pwdata[8]) begin
        // Data byte: region is the one latched at the last address set.
        ram_we <= 1'b1;
        ram_region <= ~region_basic;
        ram_addr <= addr_count;
        ram_data <= wb;
        addr_count <= addr_count + `LCDCD_ADDR_ONE;
        cursor_home_ok <= region_basic;
      end else if (wr_byte) begin
        // Command byte, decoded with the retained extended select.
        if (wb[7]) begin
          addr_count <= wb[6:0];
          region_basic <= ~extended_set_sel;
          cursor_home_ok <= ~extended_set_sel;
          // Basic area outside text RAM is icon or contrast: cursor is removed.
          cursor_hidden <= hides_cursor(extended_set_sel, wb[6:0]);
        end else begin
          case (op)
            `LCDCD_OP_TEST: begin
              // Only the zero byte clears; other codes are test entries.
              test_mode <= (wb != `LCDCD_NOP_BYTE);
            end
            `LCDCD_OP_HOME: begin
              // Home and scroll share this opcode; the extended select parts them.
              if (extended_set_sel) begin
                scroll_amount <= wb[1:0];
              end else begin
                addr_count <= `LCDCD_HOME_ADDR;
                scroll_amount <= 2'b00;
                cursor_hidden <= ~cursor_home_ok;
              end
            end
            `LCDCD_OP_LINE: begin
              // Bits follow text RAM lines, so a scroll does not move the flashing line.
              if (extended_set_sel) begin
                line_tall_font <= wb[3:0];
              end else begin
                line_flash <= wb[3:0];
              end
            end
            `LCDCD_OP_DISP: begin
              // The extended select loaded here governs later address set, home, line, power and system decodes.
              cursor_show <= wb[3];
              cursor_flash <= wb[2];
              extended_set_sel <= wb[1];
              panel_on <= wb[0];
            end
            `LCDCD_OP_PSAVE: begin
              // Bits 3:2 are ignored; the booster relies on the oscillator set here.
              osc_on <= wb[1];
              low_power_on <= wb[0];
            end
            `LCDCD_OP_PWR: begin
              if (extended_set_sel) begin
                // Bias clear selects one-fifth bias, set selects one-quarter bias.
                internal_divider_sel <= wb[3];
                lcd_bias_sel <= wb[2];
                gain_ratio <= wb[1:0];
              end else begin
                // Booster ordering against the oscillator is the host's duty.
                high_drive_on <= wb[3];
                lcd_volt_loop_on <= wb[2];
                lcd_buffer_on <= wb[1];
                booster_on <= wb[0];
              end
            end
            `LCDCD_OP_SYS: begin
              if (extended_set_sel) begin
                // Only character segments follow this flag; symbol outputs never invert.
                seg_invert <= wb[1];
              end else begin
                font_bank <= wb[3:2];
                scan_reverse <= wb[1];
                user_font_on <= wb[0];
              end
            end
            default: begin
              // Unused opcodes leave every setting as it is.
              test_mode <= test_mode;
            end
          endcase
        end
      end
    end
  end

  // Cursor rendering state, registered from the counter and control bits.
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cursor_visible <= 1'b0;
      cursor_bar <= 1'b0;
      cursor_reverse <= 1'b0;
      cursor_tall <= 1'b0;
      symbol_flash <= 1'b0;
      line_flash_now <= 4'h0;
    end else begin
      cursor_visible <= cursor_show & ~cursor_hidden;
      cursor_bar <= cursor_show & ~cursor_flash & ~cursor_hidden;
      cursor_reverse <= cursor_show & cursor_flash & ~cursor_hidden & flash_rate;
      // The tall cursor applies to the under-bar form on a tall text line only.
      cursor_tall <= cursor_show & ~cursor_flash & in_text & region_basic
                     & line_tall_font[cur_line];
      symbol_flash <= cursor_show & cursor_flash & ~region_basic & in_sym
                      & flash_rate;
      line_flash_now <= line_flash & {4{flash_rate}};
    end
  end
endmodule

/* File: lcdcd_asserts.sv */
// Port assertions for the LCD command decoder.
`timescale 1ns/1ns
module lcdcd_asserts (
  // Clock and reset.
  input wire sys_clk,
  input wire rst_b,
  // APB request and ready.
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  // Decoder state.
  input wire ram_we,
  input wire [6:0] ram_addr,
  input wire [7:0] ram_data,
  input wire [6:0] addr_count,
  input wire [1:0] scroll_amount,
  input wire cursor_show,
  input wire cursor_flash,
  input wire extended_set_sel,
  input wire panel_on,
  input wire cursor_visible,
  input wire test_mode
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // A byte is taken at the edge that closes the first access cycle.
  wire tk = psel && penable && pwrite && !pready && paddr == 12'h00c;
  wire cm = tk && !pwdata[8];
  wire [3:0] hi = pwdata[7:4];
  a_home_load: assert property (cm && hi == 4'h1 && !extended_set_sel |=>
    addr_count == 7'h30 && scroll_amount == 2'h0) else $error("home load wrong");
  a_scroll_set: assert property (cm && hi == 4'h1 && extended_set_sel |=>
    scroll_amount == $past(pwdata[1:0])) else $error("scroll wrong");
  a_disp_load: assert property (cm && hi == 4'h3 |=>
    {cursor_show, cursor_flash, extended_set_sel, panel_on} == $past(pwdata[3:0]))
    else $error("display control wrong");
  a_addr_load: assert property (cm && pwdata[7] |=>
    addr_count == $past(pwdata[6:0])) else $error("address set wrong");
  a_data_out: assert property (tk && pwdata[8] |=>
    ram_we && ram_data == $past(pwdata[7:0]) && $stable(extended_set_sel))
    else $error("data write wrong");
  a_cmd_nowr: assert property (cm |=> !ram_we) else $error("command wrote RAM");
  a_incr_wrap: assert property (ram_we |-> addr_count == ram_addr + 7'h01)
    else $error("counter did not advance");
  a_no_cursor: assert property (!cursor_show |=> !cursor_visible)
    else $error("cursor shown while off");
  a_nop_clear: assert property (cm && pwdata[7:0] == 8'h00 |=> !test_mode)
    else $error("test mode kept");
endmodule
bind lcdcd_top lcdcd_asserts u_asserts (.sys_clk, .rst_b, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pready, .ram_we, .ram_addr, .ram_data, .addr_count, .scroll_amount, .cursor_show,
  .cursor_flash, .extended_set_sel, .panel_on, .cursor_visible, .test_mode);

/* File: lcdcd_host.sv */
// APB host model issuing command and data words to the decoder.
`timescale 1ns/1ns
module lcdcd_host (
  // Clock.
  input wire sys_clk,
  // APB request.
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  // APB answer.
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr
);
  // Idle bus from time zero, so reset never sees a stray request.
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
  end
  // One transfer; the request holds until pready is seen high at an edge.
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] r, output logic e);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

/* File: lcd_command_decoder_tb.sv */
// Self-checking testbench for the LCD command decoder.
`timescale 1ns/1ns
module lcd_command_decoder_tb;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  wire psel, penable, pwrite, pready, pslverr, ram_we, ram_region;
  wire [11:0] paddr;
  wire [31:0] pwdata, prdata;
  wire cursor_show, cursor_flash, extended_set_sel, panel_on, cursor_visible, cursor_bar;
  wire cursor_reverse, cursor_tall, symbol_flash, osc_on, low_power_on, high_drive_on;
  wire lcd_volt_loop_on, lcd_buffer_on, booster_on, internal_divider_sel, lcd_bias_sel;
  wire scan_reverse, user_font_on, seg_invert, test_mode;
  wire [6:0] ram_addr, addr_count;
  wire [7:0] ram_data;
  wire [1:0] scroll_amount, gain_ratio, font_bank;
  wire [3:0] line_flash, line_tall_font, line_flash_now;
  int miscompares = 0;
  int num_checks = 0;
  int cyc = 0;
  int n1, n2;
  logic [31:0] rd;
  logic er;
  // Short flash period keeps the blink checks brief.
  lcdcd_top #(.HALF_CYCLES(4)) dut (.sys_clk, .rst_b, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .ram_we, .ram_region, .ram_addr, .ram_data,
    .addr_count, .scroll_amount, .line_flash, .line_tall_font, .line_flash_now, .cursor_show,
    .cursor_flash, .extended_set_sel, .panel_on, .cursor_visible, .cursor_bar,
    .cursor_reverse, .cursor_tall, .symbol_flash, .osc_on, .low_power_on, .high_drive_on,
    .lcd_volt_loop_on, .lcd_buffer_on, .booster_on, .internal_divider_sel, .lcd_bias_sel,
    .gain_ratio, .font_bank, .scan_reverse, .user_font_on, .seg_invert, .test_mode);
  lcdcd_host host (.sys_clk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr);
  always #25 sys_clk = ~sys_clk;
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  // Bit 8 selects data; checks follow at the falling edge, after derived state lands.
  task cmd(input logic [8:0] w);
    host.xfer(1'b1, 12'h00c, {23'h0, w}, rd, er);
    @(negedge sys_clk);
  endtask
  task rr(input logic [11:0] a);
    host.xfer(1'b0, a, 32'h0, rd, er);
  endtask
  task results;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // A hang ends the run as a mismatch.
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      miscompares++;
      results();
    end
  end
  // Addresses used here avoid basic location 09h, and the oscillator comes up first.
  initial begin
    repeat (4) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(negedge sys_clk);
    chk("divider", internal_divider_sel, 1'b1);
    rr(12'h010);
    chk("unmapped", er, 1'b1);
    cmd(9'h03a);
    chk("display", {cursor_show, cursor_flash, extended_set_sel, panel_on}, 4'ha);
    cmd(9'h013);
    chk("scroll", scroll_amount, 2'd3);
    cmd(9'h025);
    chk("tall", line_tall_font, 4'h5);
    cmd(9'h05b);
    chk("power2", {internal_divider_sel, lcd_bias_sel, gain_ratio}, 4'hb);
    cmd(9'h06e);
    chk("invert", {seg_invert, font_bank}, 3'h4);
    cmd(9'h0e0);
    cmd(9'h155);
    chk("ext data", {ram_region, ram_addr, addr_count, extended_set_sel}, 16'he0c3);
    rr(12'h000);
    chk("ctrl", rd, 32'h0000_50ca);
    cmd(9'h038);
    cmd(9'h01f);
    chk("home", {addr_count, scroll_amount, cursor_visible}, 10'h180);
    cmd(9'h0b0);
    cmd(9'h01f);
    chk("cursor", {cursor_visible, cursor_bar, cursor_tall}, 3'b111);
    cmd(9'h02f);
    cmd(9'h03c);
    n1 = 0;
    n2 = 0;
    repeat (16) begin
      @(negedge sys_clk);
      n1 += (line_flash_now === 4'hf);
      n2 += (cursor_reverse === 1'b1);
    end
    chk("line rate", n1, 8);
    chk("cursor rate", n2, 8);
    // Cursor in the extended symbol store with show and flash set.
    cmd(9'h03e);
    cmd(9'h0e0);
    n1 = 0;
    repeat (16) begin
      @(negedge sys_clk);
      n1 += (symbol_flash === 1'b1);
    end
    chk("symbol rate", n1, 8);
    cmd(9'h03c);
    cmd(9'h085);
    chk("icon", cursor_visible, 1'b0);
    cmd(9'h0ff);
    cmd(9'h112);
    chk("wrap", {addr_count, ram_data, ram_region}, 16'h0024);
    rr(12'h008);
    chk("status", rd, 32'h0000_0180);
    cmd(9'h042);
    cmd(9'h05f);
    cmd(9'h06b);
    chk("osc", {osc_on, low_power_on}, 2'b10);
    rr(12'h004);
    chk("power", rd, 32'h0000_7b7d);
    // Stands in for a stray test entry caused by noise; a real host never sends one.
    cmd(9'h005);
    chk("test on", test_mode, 1'b1);
    cmd(9'h000);
    chk("test off", test_mode, 1'b0);
    rr(12'h004);
    chk("nop keeps", rd, 32'h0000_7b7d);
    results();
  end
endmodule
